// >>> verilog/xip_pkg.sv
// Shared constants for the external interrupt port: widths, modes and the
// controller's register map. Assumes both ends run on one clock, aclk.
package xip_pkg;

  // Link field widths and the controller's source count
  localparam int LEVEL_W = 8;
  localparam int VEC_W = 6;
  localparam int SS_W = 4;
  localparam int OFS_W = 17;
  localparam int SRC_N = 11;

  localparam logic [LEVEL_W-1:0] LEVEL_NONE = 8'h00;
  localparam logic [VEC_W-1:0] VEC_COMPAT = 6'h00;

  // Interrupt modes of the core
  typedef enum logic [1:0] {
    XIP_MODE_COMPAT = 2'b00,
    XIP_MODE_VECTORED = 2'b01,
    XIP_MODE_EXT_CTRL = 2'b10
  } xip_mode_t;

  // Controller register byte offsets (AXI4-Lite, one word each)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ENABLE = 8'h04;
  localparam logic [7:0] REG_PEND = 8'h08;
  localparam logic [7:0] REG_TAKEN = 8'h0C;

  // Field positions
  localparam int CTRL_PRESENT_BIT = 0;
  localparam int CTRL_SS_LSB = 4;
  localparam int TAKEN_VEC_LSB = 8;
  localparam int TAKEN_CNT_LSB = 16;
  localparam int SRC_TIMER = 8;
  localparam int SRC_SOFT0 = 9;

  // Reset values
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] ENABLE_RESET = 32'h0000_0000;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// >>> verilog/xip_if.sv
// Link between the core's interrupt port and the external controller.
// Assumes both ends share aclk; every signal is driven from a flip-flop.
interface xip_if (
  input logic aclk,
  input logic aresetn
);
  import xip_pkg::*;

  logic [LEVEL_W-1:0] req_level;
  logic [VEC_W-1:0] req_vector_in;
  logic [SS_W-1:0] req_shadow_set_in;
  logic [OFS_W:1] req_offset_in;
  logic ext_ctrl_present;
  logic irq_taken_ack;
  logic [LEVEL_W-1:0] taken_level_out;
  logic [VEC_W-1:0] taken_vector_out;
  logic [OFS_W:1] taken_offset_out;
  logic [1:0] soft_irq_out;
  logic timer_irq_out;

  modport core (
    input req_level, req_vector_in, req_shadow_set_in, req_offset_in, ext_ctrl_present,
    output irq_taken_ack, taken_level_out, taken_vector_out, taken_offset_out,
    output soft_irq_out, timer_irq_out
  );

  modport ctrl (
    output req_level, req_vector_in, req_shadow_set_in, req_offset_in, ext_ctrl_present,
    input irq_taken_ack, taken_level_out, taken_vector_out, taken_offset_out,
    input soft_irq_out, timer_irq_out
  );
endinterface

// >>> verilog/xip_core_end.sv
// Core end of the external interrupt port: takes interrupts from the
// controller, acknowledges those taken in controller mode and exports timer and software requests.
// Assumes the controller drives the link from aclk flip-flops.
//
// Added by the designer: the AXI4-Lite interface to the registers and the placing of the registers.
module xip_core_end
  import xip_pkg::*;
(
  // Clock and reset
  input logic aclk,
  input logic aresetn,
  // Link to the interrupt controller
  xip_if.core link,
  // Core control state
  input xip_mode_t mode,
  input logic [LEVEL_W-1:0] current_level_field,
  input logic int_enable,
  input logic [9:0] int_mask,
  input logic full_offset_sel,
  input logic exc_return,
  input logic [1:0] soft_irq_bits,
  input logic count_match,
  input logic compare_write,
  // Exception entry
  output logic exc_take,
  output logic [VEC_W-1:0] exc_vector,
  output logic [OFS_W:1] exc_offset,
  output logic [SS_W-1:0] exc_shadow_set,
  output logic [LEVEL_W-1:0] requested_level_field,
  output logic [7:0] pending_bits,
  output logic in_exception
);

  logic [7:0] pin_s1_q, pin_s2_q;
  logic [7:0] pend_q, pend_d;
  logic exl_q, exl_d;
  logic take_q, take_d;
  logic ack_q, ack_d;
  logic [LEVEL_W-1:0] tlevel_q, tlevel_d;
  logic [VEC_W-1:0] tvec_q, tvec_d;
  logic [OFS_W:1] tofs_q, tofs_d;
  logic [VEC_W-1:0] evec_q, evec_d;
  logic [OFS_W:1] eofs_q, eofs_d;
  logic [SS_W-1:0] ess_q, ess_d;
  logic [LEVEL_W-1:0] ripl_q, ripl_d;
  logic [1:0] soft_q, soft_d;
  logic timer_q, timer_d;
  logic ext_mode, allow, ext_take, compat_take;
  logic [9:0] compat_req;

  // Highest set bit wins; pin 7 sits at bit 9, the soft bits at the bottom
  function automatic logic [3:0] top_index(input logic [9:0] v);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = 0; i < 10; i++) begin
      if (v[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction

  always_comb begin
    ext_mode = (mode == XIP_MODE_EXT_CTRL) && link.ext_ctrl_present;
    allow = int_enable && !exl_q;
    // Level 0 never exceeds any current level, so it never takes
    ext_take = ext_mode && allow && (link.req_level > current_level_field);
    compat_req = {pin_s2_q, soft_q} & int_mask;
    compat_take = !ext_mode && allow && (|compat_req);
  end

  // Request lines may be asynchronous outside controller mode
  always_comb begin
    pend_d = pin_s2_q;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_q <= 8'h00;
      pin_s2_q <= 8'h00;
      pend_q <= 8'h00;
    end else begin
      pin_s1_q <= link.req_level;
      pin_s2_q <= pin_s1_q;
      pend_q <= pend_d;
    end
  end

  // Exception entry; a new take waits until the previous one has returned
  always_comb begin
    exl_d = exl_q;
    take_d = 1'b0;
    evec_d = evec_q;
    eofs_d = eofs_q;
    ess_d = ess_q;
    if (exl_q && exc_return) begin
      exl_d = 1'b0;
    end
    if (ext_take) begin
      exl_d = 1'b1;
      take_d = 1'b1;
      evec_d = link.req_vector_in;
      ess_d = link.req_shadow_set_in;
      eofs_d = full_offset_sel ? link.req_offset_in : '0;
    end else if (compat_take) begin
      // Compat and vectored entries ignore the vector, shadow set and offset inputs
      exl_d = 1'b1;
      take_d = 1'b1;
      eofs_d = '0;
      ess_d = '0;
      evec_d = (mode == XIP_MODE_VECTORED) ? VEC_W'(top_index(compat_req)) : VEC_COMPAT;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      exl_q <= 1'b0;
      take_q <= 1'b0;
      evec_q <= '0;
      eofs_q <= '0;
      ess_q <= '0;
    end else begin
      exl_q <= exl_d;
      take_q <= take_d;
      evec_q <= evec_d;
      eofs_q <= eofs_d;
      ess_q <= ess_d;
    end
  end

  // Compat and vectored entries raise no acknowledge and leave the taken outputs alone
  always_comb begin
    ack_d = 1'b0;
    tlevel_d = tlevel_q;
    tvec_d = tvec_q;
    tofs_d = tofs_q;
    ripl_d = ripl_q;
    if (ext_take) begin
      ack_d = 1'b1;
      ripl_d = link.req_level;
      tlevel_d = link.req_level;
      tvec_d = link.req_vector_in;
      tofs_d = full_offset_sel ? link.req_offset_in : '0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ack_q <= 1'b0;
      tlevel_q <= LEVEL_NONE;
      tvec_q <= '0;
      tofs_q <= '0;
      ripl_q <= LEVEL_NONE;
    end else begin
      ack_q <= ack_d;
      tlevel_q <= tlevel_d;
      tvec_q <= tvec_d;
      tofs_q <= tofs_d;
      ripl_q <= ripl_d;
    end
  end

  always_comb begin
    soft_d = soft_irq_bits;
    // A match in the same cycle as a compare write keeps the flag set
    timer_d = count_match ? 1'b1 : (compare_write ? 1'b0 : timer_q);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      soft_q <= 2'b00;
      timer_q <= 1'b0;
    end else begin
      soft_q <= soft_d;
      timer_q <= timer_d;
    end
  end

  assign link.irq_taken_ack = ack_q;
  assign link.taken_level_out = tlevel_q;
  assign link.taken_vector_out = tvec_q;
  assign link.taken_offset_out = tofs_q;
  assign link.soft_irq_out = soft_q;
  assign link.timer_irq_out = timer_q;
  assign exc_take = take_q;
  assign exc_vector = evec_q;
  assign exc_offset = eofs_q;
  assign exc_shadow_set = ess_q;
  assign requested_level_field = ripl_q;
  assign pending_bits = pend_q;
  assign in_exception = exl_q;

endmodule // xip_core_end

// >>> verilog/xip_ctrl_end.sv
// External interrupt controller end: prioritises eight pins plus the core's
// timer and software requests and drives the encoded request onto the link.
// Assumes software reaches its registers over AXI4-Lite on aclk.
module xip_ctrl_end
  import xip_pkg::*;
(
  // Clock and reset
  input logic aclk,
  input logic aresetn,
  // Link to the core
  xip_if.ctrl link,
  // System interrupt pins, asynchronous
  input logic [7:0] src_irq,
  // AXI4-Lite write
  input logic awvalid,
  output logic awready,
  input logic [7:0] awaddr,
  input logic wvalid,
  output logic wready,
  input logic [31:0] wdata,
  input logic [3:0] wstrb,
  output logic bvalid,
  input logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read
  input logic arvalid,
  output logic arready,
  input logic [7:0] araddr,
  output logic rvalid,
  input logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp
);

  logic [7:0] src_s1_q, src_s2_q;
  logic [31:0] ctrl_q, ctrl_d, en_q, en_d, taken_q, taken_d;
  logic [LEVEL_W-1:0] lvl_q, lvl_d;
  logic [VEC_W-1:0] vec_q, vec_d;
  logic [SS_W-1:0] ss_q, ss_d;
  logic [OFS_W:1] ofs_q, ofs_d;
  logic awr_q, awr_d, wr_q, wr_d, bv_q, bv_d, arr_q, arr_d, rv_q, rv_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d, wmask;
  logic [SRC_N-1:0] pend;
  logic [3:0] top;

  always_comb begin
    pend = {link.soft_irq_out, link.timer_irq_out, src_s2_q} & en_q[SRC_N-1:0];
    top = 4'h0;
    for (int i = 0; i < SRC_N; i++) begin
      if (pend[i]) begin
        top = 4'(i);
      end
    end
    wmask = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
    ctrl_d = ctrl_q;
    en_d = en_q;
    taken_d = taken_q;
    // Source i asks at level i+1, so the top source wins and 0 means idle
    if (ctrl_q[CTRL_PRESENT_BIT] && (|pend)) begin
      lvl_d = LEVEL_W'(top) + 8'h01;
    end else begin
      lvl_d = LEVEL_NONE;
    end
    vec_d = VEC_W'(lvl_d);
    ofs_d = {5'h00, lvl_d, 4'h0};
    ss_d = ctrl_q[CTRL_SS_LSB +: SS_W];
    if (link.irq_taken_ack) begin
      taken_d[LEVEL_W-1:0] = link.taken_level_out;
      taken_d[TAKEN_VEC_LSB +: VEC_W] = link.taken_vector_out;
      taken_d[31:TAKEN_CNT_LSB] = taken_q[31:TAKEN_CNT_LSB] + 16'h0001;
    end

    awr_d = 1'b0;
    wr_d = 1'b0;
    bv_d = bv_q && !bready;
    bresp_d = bresp_q;
    if (awvalid && wvalid && !awr_q && !bv_q) begin
      awr_d = 1'b1;
      wr_d = 1'b1;
    end
    if (awr_q) begin
      bv_d = 1'b1;
      bresp_d = RESP_OKAY;
      case (awaddr)
        REG_CTRL: ctrl_d = (ctrl_q & ~wmask) | (wdata & wmask);
        REG_ENABLE: en_d = (en_q & ~wmask) | (wdata & wmask);
        REG_PEND, REG_TAKEN: ;
        default: bresp_d = RESP_SLVERR;
      endcase
    end

    arr_d = arvalid && !arr_q && !rv_q;
    rv_d = rv_q && !rready;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (arr_q) begin
      rv_d = 1'b1;
      rresp_d = RESP_OKAY;
      case (araddr)
        REG_CTRL: rdata_d = ctrl_q;
        REG_ENABLE: rdata_d = en_q;
        REG_PEND: rdata_d = {21'h000000, pend};
        REG_TAKEN: rdata_d = taken_q;
        default: begin
          rdata_d = 32'h0000_0000;
          rresp_d = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_s1_q <= 8'h00;
      src_s2_q <= 8'h00;
      ctrl_q <= CTRL_RESET;
      en_q <= ENABLE_RESET;
      taken_q <= 32'h0000_0000;
      lvl_q <= LEVEL_NONE;
      vec_q <= '0;
      ss_q <= '0;
      ofs_q <= '0;
      awr_q <= 1'b0;
      wr_q <= 1'b0;
      bv_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      arr_q <= 1'b0;
      rv_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else begin
      src_s1_q <= src_irq;
      src_s2_q <= src_s1_q;
      ctrl_q <= ctrl_d;
      en_q <= en_d;
      taken_q <= taken_d;
      // Level, vector, shadow set and offset all move on the same edge
      lvl_q <= lvl_d;
      vec_q <= vec_d;
      ss_q <= ss_d;
      ofs_q <= ofs_d;
      awr_q <= awr_d;
      wr_q <= wr_d;
      bv_q <= bv_d;
      bresp_q <= bresp_d;
      arr_q <= arr_d;
      rv_q <= rv_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  assign link.req_level = lvl_q;
  assign link.req_vector_in = vec_q;
  assign link.req_shadow_set_in = ss_q;
  assign link.req_offset_in = ofs_q;
  assign link.ext_ctrl_present = ctrl_q[CTRL_PRESENT_BIT];
  assign awready = awr_q;
  assign wready = wr_q;
  assign bvalid = bv_q;
  assign bresp = bresp_q;
  assign arready = arr_q;
  assign rvalid = rv_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

endmodule // xip_ctrl_end

// >>> sim/xip_link_properties.sv
// Concurrent checks on the link between core end and controller end.
// Assumes one clock, aclk, and a synchronous active-low aresetn.
module xip_link_chk
  import xip_pkg::*;
(
  // Clock and reset
  input logic aclk,
  input logic aresetn,
  // Controller to core
  input logic [LEVEL_W-1:0] req_level,
  input logic [VEC_W-1:0] req_vector_in,
  input logic [OFS_W:1] req_offset_in,
  input logic ext_ctrl_present,
  // Core to controller
  input logic irq_taken_ack,
  input logic [LEVEL_W-1:0] taken_level_out,
  input logic [VEC_W-1:0] taken_vector_out,
  input logic [OFS_W:1] taken_offset_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence ack_pulse_s;
    irq_taken_ack ##1 !irq_taken_ack;
  endsequence

  sequence taken_still_s;
    $stable(taken_level_out) && $stable(taken_vector_out) && $stable(taken_offset_out);
  endsequence

  ack_one_cycle_a: assert property (irq_taken_ack |-> ack_pulse_s)
    else $error("acknowledge longer than one cycle");
  taken_hold_a: assert property (!irq_taken_ack |-> taken_still_s)
    else $error("taken outputs moved without acknowledge");
  ack_level_a: assert property (irq_taken_ack |-> taken_level_out == $past(req_level))
    else $error("taken level differs from sampled request");
  ack_vector_a: assert property (irq_taken_ack |-> taken_vector_out == $past(req_vector_in))
    else $error("taken vector differs from sampled vector");
  ack_present_a: assert property (irq_taken_ack |-> $past(ext_ctrl_present))
    else $error("acknowledge without controller present");
  ack_nonzero_a: assert property (irq_taken_ack |-> $past(req_level) != LEVEL_NONE)
    else $error("acknowledge for level zero");
  req_vector_a: assert property (req_vector_in == req_level[VEC_W-1:0])
    else $error("request vector does not follow level");
  req_offset_a: assert property (req_offset_in == {5'h00, req_level, 4'h0})
    else $error("request offset does not follow level");
endmodule // xip_link_chk

// >>> sim/tb_top.sv
// Bench: core end and controller end joined by the link interface.
// Assumes a 40 MHz aclk; all inputs change by non-blocking assignment.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import xip_pkg::*;

  logic aclk, aresetn;
  xip_mode_t mode;
  logic int_enable, full_offset_sel, exc_return, count_match, compare_write;
  logic [9:0] int_mask;
  logic [1:0] soft_irq_bits, bresp, rresp;
  logic exc_take, in_exception;
  logic [VEC_W-1:0] exc_vector;
  logic [OFS_W:1] exc_offset;
  logic [SS_W-1:0] exc_shadow_set;
  logic [7:0] current_level_field, requested_level_field, pending_bits, src_irq, awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  int mismatches = 0;
  int samples_checked = 0;
  int take_cnt = 0;
  int ack_cnt = 0;

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  xip_if link_if (.aclk, .aresetn);
  xip_core_end xip_core_end_inst (.aclk, .aresetn, .link(link_if), .mode, .current_level_field,
    .int_enable, .int_mask, .full_offset_sel, .exc_return, .soft_irq_bits, .count_match,
    .compare_write, .exc_take, .exc_vector, .exc_offset, .exc_shadow_set,
    .requested_level_field, .pending_bits, .in_exception);
  xip_ctrl_end xip_ctrl_end_inst (.aclk, .aresetn, .link(link_if), .src_irq, .awvalid,
    .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid,
    .arready, .araddr, .rvalid, .rready, .rdata, .rresp);
  xip_link_chk xip_link_chk_inst (.aclk, .aresetn, .req_level(link_if.req_level),
    .req_vector_in(link_if.req_vector_in), .req_offset_in(link_if.req_offset_in),
    .ext_ctrl_present(link_if.ext_ctrl_present), .irq_taken_ack(link_if.irq_taken_ack),
    .taken_level_out(link_if.taken_level_out), .taken_vector_out(link_if.taken_vector_out),
    .taken_offset_out(link_if.taken_offset_out));

  // Pulse counters, so no one-cycle output can slip past a slow check
  always @(posedge aclk) begin
    if (exc_take === 1'b1) take_cnt <= take_cnt + 1;
    if (link_if.irq_taken_ack === 1'b1) ack_cnt <= ack_cnt + 1;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic guard(input int n);
    if (n >= 60) begin
      mismatches++;
      wrap_up();
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 60);
    bready <= 1'b0;
    guard(n);
    check("bresp", 32'(bresp), 32'(er));
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    int n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 60);
    rready <= 1'b0;
    guard(n);
    check("rdata", rdata, exp);
    check("rresp", 32'(rresp), 32'(er));
  endtask

  task automatic wait_take(input int k);
    int n = 0;
    while (take_cnt < k && n < 60) begin
      @(posedge aclk);
      n++;
    end
    tick(1);
    guard(n);
  endtask

  // Interrupts are switched on only as the return pulse ends, so the same request cannot slip in early
  task automatic reenter();
    @(posedge aclk);
    exc_return <= 1'b1;
    @(posedge aclk);
    exc_return <= 1'b0;
    int_enable <= 1'b1;
  endtask

  initial begin
    aresetn = 1'b0;
    mode = XIP_MODE_COMPAT;
    wstrb = 4'hF;
    {int_enable, full_offset_sel, exc_return, count_match, compare_write} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, src_irq, int_mask, soft_irq_bits, current_level_field} = '0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    tick(1);
    check("present", 32'(link_if.ext_ctrl_present), 32'h0);
    axi_rd(REG_CTRL, CTRL_RESET, RESP_OKAY);
    axi_rd(8'h10, 32'h0, RESP_SLVERR);
    axi_wr(8'h10, 32'hFFFF_FFFF, RESP_SLVERR);
    axi_wr(REG_CTRL, 32'h0000_0051, RESP_OKAY);
    axi_wr(REG_ENABLE, 32'h0000_0004, RESP_OKAY);
    axi_rd(REG_CTRL, 32'h0000_0051, RESP_OKAY);
    @(posedge aclk);
    src_irq <= 8'h04;
    int_mask <= 10'h3FF;
    int_enable <= 1'b1;
    wait_take(1);
    check("pending", 32'(pending_bits), 32'h03);
    check("compat vector", 32'(exc_vector), 32'(VEC_COMPAT));
    @(posedge aclk);
    int_enable <= 1'b0;
    mode <= XIP_MODE_VECTORED;
    reenter();
    wait_take(2);
    check("no ack", 32'(ack_cnt), 32'h0);
    check("vectored vector", 32'(exc_vector), 32'h03);
    @(posedge aclk);
    int_enable <= 1'b0;
    mode <= XIP_MODE_EXT_CTRL;
    current_level_field <= 8'h03;
    full_offset_sel <= 1'b1;
    reenter();
    tick(8);
    check("equal level", 32'(take_cnt), 32'h2);
    @(posedge aclk);
    current_level_field <= 8'h02;
    wait_take(3);
    check("ack", 32'(ack_cnt), 32'h1);
    check("in exception", 32'(in_exception), 32'h1);
    check("cause level", 32'(requested_level_field), 32'h03);
    check("taken level", 32'(link_if.taken_level_out), 32'h03);
    check("vector", 32'(exc_vector), 32'h03);
    check("taken vector", 32'(link_if.taken_vector_out), 32'h03);
    check("offset", 32'(exc_offset), 32'h30);
    check("taken offset", 32'(link_if.taken_offset_out), 32'h30);
    check("shadow", 32'(exc_shadow_set), 32'h5);
    axi_rd(REG_TAKEN, 32'h0001_0303, RESP_OKAY);
    @(posedge aclk);
    src_irq <= 8'h24;
    axi_wr(REG_ENABLE, 32'h0000_0024, RESP_OKAY);
    tick(8);
    check("top level", 32'(link_if.req_level), 32'h06);
    check("blocked", 32'(take_cnt), 32'h3);
    @(posedge aclk);
    full_offset_sel <= 1'b0;
    reenter();
    wait_take(4);
    check("second level", 32'(link_if.taken_level_out), 32'h06);
    check("unused offset", 32'(link_if.taken_offset_out), 32'h0);
    check("acks", 32'(ack_cnt), 32'h2);
    @(posedge aclk);
    src_irq <= 8'h00;
    axi_wr(REG_ENABLE, 32'h0000_0500, RESP_OKAY);
    @(posedge aclk);
    count_match <= 1'b1;
    tick(1);
    check("timer set", 32'(link_if.timer_irq_out), 32'h1);
    @(posedge aclk);
    count_match <= 1'b0;
    tick(6);
    check("timer level", 32'(link_if.req_level), 32'h09);
    @(posedge aclk);
    soft_irq_bits <= 2'b10;
    tick(1);
    check("soft out", 32'(link_if.soft_irq_out), 32'h2);
    tick(6);
    check("soft level", 32'(link_if.req_level), 32'h0B);
    @(posedge aclk);
    compare_write <= 1'b1;
    tick(1);
    check("timer clear", 32'(link_if.timer_irq_out), 32'h0);
    @(posedge aclk);
    count_match <= 1'b1;
    tick(1);
    check("timer set wins", 32'(link_if.timer_irq_out), 32'h1);
    @(posedge aclk);
    {count_match, compare_write} <= 2'b00;
    axi_wr(REG_CTRL, 32'h0000_0050, RESP_OKAY);
    reenter();
    wait_take(5);
    check("absent acks", 32'(ack_cnt), 32'h2);
    check("absent vector", 32'(exc_vector), 32'(VEC_COMPAT));
    check("absent shadow", 32'(exc_shadow_set), 32'h0);
    check("absent exception", 32'(in_exception), 32'h1);
    wrap_up();
  end
endmodule // tb_top
